// ===== sru_top.sv
// Behaviour
// - Logical shifts drop bits moved out and fill vacated positions with zeros.
// - Variable logical shift distance is low six bits, sign extended; positive shifts left.
// - Distance beyond destination width gives zero; distance zero leaves value unchanged.
// - Pointer-destination shifts leave all status flags untouched.
// - Data-register shift sets zero and negative from result, clears data overflow.
// - Accumulator zero shift sets zero and negative, clears its overflow flag.
// - Accumulator one shift sets zero and negative, clears its overflow flag.
// - Short-encoded shifts may not be paired; long forms may pair.
// - Rotate chain includes the condition bit; its old value enters first.
// - Bit leaving the register goes to condition bit; old condition enters opposite end.
// - Positive rotate distance rotates left, negative rotates right.
// - Rotate distance spans minus 32 to plus 31; higher distance bits ignored.
// - Rotate distance comes from six-bit constant or data register low half.
// - Last bit rotated out stays in condition bit, not written back.
// - Rotation takes the same single-step latency for every distance.
// - Data rotates cover 32 bits; accumulator rotates cover 40 bits.
// - Source stays unchanged unless destination is the same register.
// - Rotate alters only the condition bit among the status flags.
// - All rotate forms need the long encoding.
//
// The register addresses and the APB register port were chosen for this implementation.
module sru_top
	import sru_pkg::*;
(
	input  wire logic              CLK_SYS,
	input  wire logic              RESET_N,
	input  wire logic              PSEL,
	input  wire logic              PENABLE,
	input  wire logic              PWRITE,
	input  wire logic [ADDR_W-1:0] PADDR,
	input  wire logic [DATA_W-1:0] PWDATA,
	output logic      [DATA_W-1:0] PRDATA,
	output logic                   PREADY,
	output logic                   PSLVERR
);

	logic [ACC_W-1:0]  src_q,     src_d;
	logic [DATA_W-1:0] dist_q,    dist_d;
	sru_ctrl_t         ctrl_q,    ctrl_d;
	sru_flags_t        flags_q,   flags_d;
	logic [ACC_W-1:0]  res_q,     res_d;
	logic              illegal_q, illegal_d;
	sru_state_t        state_q,   state_d;
	logic [DATA_W-1:0] prdata_q,  prdata_d;
	logic              pslverr_q, pslverr_d;

	logic              wr_acc;
	logic              is_acc;
	logic              is_rot;
	logic              is_lsh;
	logic              bad_op;
	logic              go_left;
	logic [DATA_W-1:0] go_mag;
	logic [6:0]        mag6;
	logic [DATA_W-1:0] r32;
	logic [ACC_W-1:0]  r40;
	logic              cnd32;
	logic              cnd40;
	logic [ACC_W-1:0]  res_w;
	logic              cnd_w;
	sru_flags_t        flags_w;

	// Zero wait states: every access completes in its first access cycle
	assign PREADY  = 1'b1;
	assign PRDATA  = prdata_q;
	assign PSLVERR = pslverr_q;
	assign wr_acc  = PSEL && PENABLE && PWRITE;

	// Operation decode from the latched control word
	always_comb begin
		is_acc = (ctrl_q.dst == SRU_DST_ACC0) || (ctrl_q.dst == SRU_DST_ACC1);
		is_rot = (ctrl_q.op == SRU_OP_ROT);
		is_lsh = (ctrl_q.op == SRU_OP_LSH);
		bad_op = (ctrl_q.op > SRU_OP_ROT);
		// Short forms issue alone; rotates exist only in the long form
		if (ctrl_q.enc16 && ctrl_q.paired) begin
			bad_op = 1'b1;
		end
		if (is_rot && ctrl_q.enc16) begin
			bad_op = 1'b1;
		end
		// Short forms only target data registers; pointer short forms are refused below
		if (ctrl_q.enc16 && is_acc) begin
			bad_op = 1'b1;
		end
		// Pointers take fixed shifts of one or two places only
		if (ctrl_q.dst == SRU_DST_PTR) begin
			if ((is_rot || is_lsh) || ctrl_q.enc16 || !((dist_q == 32'h0000_0001) || (dist_q == 32'h0000_0002))) begin
				bad_op = 1'b1;
			end
		end
		// Signed forms look only at the low six distance bits
		mag6 = sru_mag6(dist_q[5:0]);
		if (is_rot || is_lsh) begin
			go_left = mag6[6];
			go_mag  = {26'h000_0000, mag6[5:0]};
		end else begin
			go_left = (ctrl_q.op == SRU_OP_SHL);
			go_mag  = dist_q; // Whole word counts for the constant-distance forms
		end
	end

	// Word-wide engine for pointer and data registers
	sru_shift_unit #(
		.W(DATA_W)
	) u_shift32 (
		.val     (src_q[DATA_W-1:0]),
		.cnd_in  (flags_q.condition_bit),
		.rotate  (is_rot),
		.left    (go_left),
		.mag     (go_mag),
		.res     (r32),
		.cnd_out (cnd32)
	);

	// Full accumulator-wide engine
	sru_shift_unit #(
		.W(ACC_W)
	) u_shift40 (
		.val     (src_q),
		.cnd_in  (flags_q.condition_bit),
		.rotate  (is_rot),
		.left    (go_left),
		.mag     (go_mag),
		.res     (r40),
		.cnd_out (cnd40)
	);

	// Result and flag update per destination kind
	always_comb begin
		res_w   = is_acc ? r40 : {8'h00, r32};
		cnd_w   = is_acc ? cnd40 : cnd32;
		flags_w = flags_q;
		if (is_rot) begin
			flags_w.condition_bit = cnd_w;
		end else begin
			unique case (ctrl_q.dst)
				SRU_DST_PTR: begin
					flags_w = flags_q;
				end
				SRU_DST_DREG: begin
					flags_w.zero_flag          = (r32 == WORD_RST);
					flags_w.negative_flag      = r32[DATA_W-1];
					flags_w.data_overflow_flag = 1'b0;
				end
				SRU_DST_ACC0: begin
					flags_w.zero_flag          = (r40 == ACC_RST);
					flags_w.negative_flag      = r40[ACC_W-1];
					flags_w.acc0_overflow_flag = 1'b0;
				end
				SRU_DST_ACC1: begin
					flags_w.zero_flag          = (r40 == ACC_RST);
					flags_w.negative_flag      = r40[ACC_W-1];
					flags_w.acc1_overflow_flag = 1'b0;
				end
			endcase
		end
	end

	// Register writes and the single execute step
	always_comb begin
		src_d     = src_q;
		dist_d    = dist_q;
		ctrl_d    = ctrl_q;
		flags_d   = flags_q;
		res_d     = res_q;
		illegal_d = illegal_q;
		state_d   = state_q;
		if (wr_acc) begin
			case (PADDR)
				OFF_SRC_LO: src_d[DATA_W-1:0] = PWDATA;
				OFF_SRC_HI: src_d[ACC_W-1:DATA_W] = PWDATA[HI_W-1:0];
				OFF_DIST:   dist_d = PWDATA;
				OFF_CTRL: begin
					ctrl_d  = sru_ctrl_t'(PWDATA[CTRL_W-1:0] & CTRL_MASK);
					state_d = ST_EXEC;
				end
				OFF_FLAGS:  flags_d = sru_flags_t'(PWDATA[FLAGS_W-1:0]);
				OFF_STATUS: begin
					if (PWDATA[STAT_ILL_BIT]) begin
						illegal_d = 1'b0;
					end
				end
				default: ;
			endcase
		end
		// Execute comes last so a hardware update beats a same-cycle clear
		unique case (state_q)
			ST_IDLE: ;
			ST_EXEC: begin
				state_d = ST_IDLE;
				if (bad_op) begin
					illegal_d = 1'b1;
				end else begin
					res_d   = res_w;
					flags_d = flags_w;
					// Source is rewritten only when it is also the destination
					if (ctrl_q.wb) begin
						src_d = is_acc ? res_w : {src_q[ACC_W-1:DATA_W], res_w[DATA_W-1:0]};
					end
				end
			end
		endcase
	end

	always_ff @(posedge CLK_SYS or negedge RESET_N) begin
		if (!RESET_N) begin
			src_q     <= ACC_RST;
			dist_q    <= WORD_RST;
			ctrl_q    <= CTRL_RST;
			flags_q   <= FLAGS_RST;
			res_q     <= ACC_RST;
			illegal_q <= 1'b0;
			state_q   <= ST_IDLE;
		end else begin
			src_q     <= src_d;
			dist_q    <= dist_d;
			ctrl_q    <= ctrl_d;
			flags_q   <= flags_d;
			res_q     <= res_d;
			illegal_q <= illegal_d;
			state_q   <= state_d;
		end
	end

	// Read data is fetched in the setup cycle so it comes from a flip-flop
	always_comb begin
		prdata_d  = prdata_q;
		pslverr_d = pslverr_q;
		if (PSEL && !PENABLE) begin
			pslverr_d = 1'b0;
			prdata_d  = WORD_RST;
			case (PADDR)
				OFF_SRC_LO: prdata_d = src_q[DATA_W-1:0];
				OFF_SRC_HI: prdata_d = {24'h00_0000, src_q[ACC_W-1:DATA_W]};
				OFF_DIST:   prdata_d = dist_q;
				OFF_CTRL:   prdata_d = DATA_W'(ctrl_q);
				OFF_FLAGS:  prdata_d = DATA_W'(flags_q);
				OFF_RES_LO: prdata_d = res_q[DATA_W-1:0];
				OFF_RES_HI: prdata_d = {24'h00_0000, res_q[ACC_W-1:DATA_W]};
				OFF_STATUS: prdata_d = {30'h0000_0000, illegal_q, state_q == ST_EXEC};
				default:    pslverr_d = 1'b1; // Unmapped: error, read zero
			endcase
			if (!PWRITE) begin
				prdata_d = pslverr_d ? WORD_RST : prdata_d;
			end else begin
				prdata_d = WORD_RST;
			end
		end
	end

	always_ff @(posedge CLK_SYS or negedge RESET_N) begin
		if (!RESET_N) begin
			prdata_q  <= WORD_RST;
			pslverr_q <= 1'b0;
		end else begin
			prdata_q  <= prdata_d;
			pslverr_q <= pslverr_d;
		end
	end

	// Snapshot of the operands for the checks below
	logic [ACC_W-1:0] snap_src_q;
	logic             snap_cnd_q;
	logic             exec_ok;
	assign exec_ok = (state_q == ST_EXEC) && !bad_op;

	always_ff @(posedge CLK_SYS or negedge RESET_N) begin
		if (!RESET_N) begin
			snap_src_q <= ACC_RST;
			snap_cnd_q <= 1'b0;
		end else begin
			snap_src_q <= src_q;
			snap_cnd_q <= flags_q.condition_bit;
		end
	end

	property p_shl_one;
		@(posedge CLK_SYS) disable iff (!RESET_N)
		exec_ok && ctrl_q.op == SRU_OP_SHL && ctrl_q.dst == SRU_DST_DREG && dist_q == 32'h0000_0001
		|=> res_q[DATA_W-1:0] == {snap_src_q[DATA_W-2:0], 1'b0};
	endproperty
	a_shl_one: assert property (p_shl_one) else $error("left shift by one wrong");

	property p_lsh_right;
		@(posedge CLK_SYS) disable iff (!RESET_N)
		exec_ok && is_lsh && ctrl_q.dst == SRU_DST_DREG && dist_q[5:0] == 6'h3F
		|=> res_q[DATA_W-1:0] == {1'b0, snap_src_q[DATA_W-1:1]};
	endproperty
	a_lsh_right: assert property (p_lsh_right) else $error("negative distance did not shift right");

	property p_far_zero;
		@(posedge CLK_SYS) disable iff (!RESET_N)
		exec_ok && !is_rot && !is_lsh && ctrl_q.dst == SRU_DST_DREG && dist_q > 32'h0000_0020
		|=> res_q == ACC_RST;
	endproperty
	a_far_zero: assert property (p_far_zero) else $error("oversized shift not zero");

	property p_ptr_flags;
		@(posedge CLK_SYS) disable iff (!RESET_N)
		exec_ok && ctrl_q.dst == SRU_DST_PTR |=> flags_q == $past(flags_q);
	endproperty
	a_ptr_flags: assert property (p_ptr_flags) else $error("pointer shift changed flags");

	property p_dreg_flags;
		@(posedge CLK_SYS) disable iff (!RESET_N)
		exec_ok && !is_rot && ctrl_q.dst == SRU_DST_DREG
		|=> flags_q.zero_flag == (res_q[DATA_W-1:0] == WORD_RST) && flags_q.negative_flag == res_q[DATA_W-1]
			&& !flags_q.data_overflow_flag && flags_q.condition_bit == snap_cnd_q;
	endproperty
	a_dreg_flags: assert property (p_dreg_flags) else $error("data shift flags wrong");

	property p_acc0_flags;
		@(posedge CLK_SYS) disable iff (!RESET_N)
		exec_ok && !is_rot && ctrl_q.dst == SRU_DST_ACC0
		|=> flags_q.zero_flag == (res_q == ACC_RST) && flags_q.negative_flag == res_q[ACC_W-1]
			&& !flags_q.acc0_overflow_flag && flags_q.acc1_overflow_flag == $past(flags_q.acc1_overflow_flag);
	endproperty
	a_acc0_flags: assert property (p_acc0_flags) else $error("accumulator zero flags wrong");

	property p_acc1_flags;
		@(posedge CLK_SYS) disable iff (!RESET_N)
		exec_ok && !is_rot && ctrl_q.dst == SRU_DST_ACC1
		|=> flags_q.zero_flag == (res_q == ACC_RST) && flags_q.negative_flag == res_q[ACC_W-1]
			&& !flags_q.acc1_overflow_flag && flags_q.acc0_overflow_flag == $past(flags_q.acc0_overflow_flag);
	endproperty
	a_acc1_flags: assert property (p_acc1_flags) else $error("accumulator one flags wrong");

	property p_no_pair;
		@(posedge CLK_SYS) disable iff (!RESET_N)
		state_q == ST_EXEC && ctrl_q.enc16 && ctrl_q.paired |=> illegal_q && $stable(res_q);
	endproperty
	a_no_pair: assert property (p_no_pair) else $error("paired short form executed");

	property p_rol_one;
		@(posedge CLK_SYS) disable iff (!RESET_N)
		exec_ok && is_rot && ctrl_q.dst == SRU_DST_DREG && dist_q[5:0] == 6'h01
		|=> res_q[DATA_W-1:0] == {snap_src_q[DATA_W-2:0], snap_cnd_q} && flags_q.condition_bit == snap_src_q[DATA_W-1];
	endproperty
	a_rol_one: assert property (p_rol_one) else $error("rotate left through condition bit wrong");

	property p_ror_one;
		@(posedge CLK_SYS) disable iff (!RESET_N)
		exec_ok && is_rot && ctrl_q.dst == SRU_DST_ACC0 && dist_q[5:0] == 6'h3F
		|=> res_q == {snap_cnd_q, snap_src_q[ACC_W-1:1]} && flags_q.condition_bit == snap_src_q[0];
	endproperty
	a_ror_one: assert property (p_ror_one) else $error("rotate right through condition bit wrong");

	property p_latency;
		@(posedge CLK_SYS) disable iff (!RESET_N)
		wr_acc && PADDR == OFF_CTRL |=> state_q == ST_EXEC ##1 state_q == ST_IDLE;
	endproperty
	a_latency: assert property (p_latency) else $error("execute latency not one cycle");

	property p_src_kept;
		@(posedge CLK_SYS) disable iff (!RESET_N)
		exec_ok && !ctrl_q.wb |=> src_q == snap_src_q;
	endproperty
	a_src_kept: assert property (p_src_kept) else $error("source modified without writeback");

	property p_rot_flags;
		@(posedge CLK_SYS) disable iff (!RESET_N)
		exec_ok && is_rot |=> flags_q[FLAGS_W-1:1] == $past(flags_q[FLAGS_W-1:1]);
	endproperty
	a_rot_flags: assert property (p_rot_flags) else $error("rotate touched other flags");

	property p_rot_long;
		@(posedge CLK_SYS) disable iff (!RESET_N)
		state_q == ST_EXEC && is_rot && ctrl_q.enc16 |=> illegal_q && $stable(flags_q);
	endproperty
	a_rot_long: assert property (p_rot_long) else $error("short rotate executed");

	property p_rot_zero;
		@(posedge CLK_SYS) disable iff (!RESET_N)
		exec_ok && is_rot && is_acc && dist_q[5:0] == 6'h00
		|=> res_q == snap_src_q && flags_q.condition_bit == snap_cnd_q;
	endproperty
	a_rot_zero: assert property (p_rot_zero) else $error("zero rotate changed state");

endmodule : sru_top

// ===== sru_shift_unit.sv
package sru_pkg;

	// Datapath widths
	localparam int DATA_W  = 32;
	localparam int ACC_W   = 40;
	localparam int HI_W    = ACC_W - DATA_W;
	localparam int ADDR_W  = 8;
	localparam int FLAGS_W = 6;
	localparam int CTRL_W  = 13;

	// Register byte offsets
	localparam logic [ADDR_W-1:0] OFF_SRC_LO = 8'h00;
	localparam logic [ADDR_W-1:0] OFF_SRC_HI = 8'h04;
	localparam logic [ADDR_W-1:0] OFF_DIST   = 8'h08;
	localparam logic [ADDR_W-1:0] OFF_CTRL   = 8'h0C;
	localparam logic [ADDR_W-1:0] OFF_FLAGS  = 8'h10;
	localparam logic [ADDR_W-1:0] OFF_RES_LO = 8'h14;
	localparam logic [ADDR_W-1:0] OFF_RES_HI = 8'h18;
	localparam logic [ADDR_W-1:0] OFF_STATUS = 8'h1C;

	// Status bit positions
	localparam int STAT_BUSY_BIT = 0;
	localparam int STAT_ILL_BIT  = 1;

	// Writable control bits; the rest read as zero
	localparam logic [CTRL_W-1:0] CTRL_MASK = 13'h1337;

	// Reset values
	localparam logic [DATA_W-1:0] WORD_RST = 32'h0000_0000;
	localparam logic [ACC_W-1:0]  ACC_RST  = 40'h00_0000_0000;

	typedef enum logic [2:0] {
		SRU_OP_SHR = 3'b000,
		SRU_OP_SHL = 3'b001,
		SRU_OP_LSH = 3'b010,
		SRU_OP_ROT = 3'b011
	} sru_op_t;

	typedef enum logic [1:0] {
		SRU_DST_PTR  = 2'b00,
		SRU_DST_DREG = 2'b01,
		SRU_DST_ACC0 = 2'b10,
		SRU_DST_ACC1 = 2'b11
	} sru_dst_t;

	typedef enum logic {
		ST_IDLE = 1'b0,
		ST_EXEC = 1'b1
	} sru_state_t;

	// Control word layout, bit 0 upward: op, pad, dest, pad, enc16, paired, pad, writeback
	typedef struct packed {
		logic       wb;
		logic [1:0] rsv2;
		logic       paired;
		logic       enc16;
		logic [1:0] rsv1;
		sru_dst_t   dst;
		logic       rsv0;
		logic [2:0] op;
	} sru_ctrl_t;

	// Status flag layout, condition bit in bit 0
	typedef struct packed {
		logic acc1_overflow_flag;
		logic acc0_overflow_flag;
		logic data_overflow_flag;
		logic negative_flag;
		logic zero_flag;
		logic condition_bit;
	} sru_flags_t;

	localparam sru_flags_t FLAGS_RST = 6'h00;
	localparam sru_ctrl_t  CTRL_RST  = 13'h0000;

	// Signed six-bit distance into direction (left when non-negative) and magnitude
	function automatic logic [6:0] sru_mag6(input logic [5:0] f);
		logic [5:0] neg;
		neg = 6'(~f + 6'h01);
		sru_mag6 = f[5] ? {1'b0, neg} : {1'b1, f};
	endfunction : sru_mag6

endpackage : sru_pkg

// Shift or rotate-through-condition-bit engine for one operand width
module sru_shift_unit
	import sru_pkg::*;
#(
	parameter int W = ACC_W
) (
	input  wire logic [W-1:0]      val,
	input  wire logic              cnd_in,
	input  wire logic              rotate,
	input  wire logic              left,
	input  wire logic [DATA_W-1:0] mag,
	output logic      [W-1:0]      res,
	output logic                   cnd_out
);

	logic [W:0]       chain;
	logic [2*W+1:0]   dbl;
	logic [2*W+1:0]   rol;
	logic [2*W+1:0]   ror;

	// One barrel pass: every distance costs the same, no bit-serial walk
	always_comb begin
		chain = {cnd_in, val};
		dbl   = {chain, chain};
		rol   = dbl << mag[5:0];
		ror   = dbl >> mag[5:0];
		if (rotate) begin
			// Condition bit sits in the ring; the last bit out lands in it
			if (left) begin
				{cnd_out, res} = rol[2*W+1:W+1];
			end else begin
				{cnd_out, res} = ror[W:0];
			end
		end else begin
			cnd_out = cnd_in;
			// Distances at or past the width flush everything to zero
			if (mag >= DATA_W'(W)) begin
				res = '0;
			end else if (left) begin
				res = val << mag;
			end else begin
				res = val >> mag;
			end
		end
	end

endmodule : sru_shift_unit

// ===== shift_rotate_unit_test.sv
module shift_rotate_unit_test
	import sru_pkg::*;
;
	timeunit 1ns;
	timeprecision 1ns;

	logic              clk_sys;
	logic              reset_n;
	logic              psel;
	logic              penable;
	logic              pwrite;
	logic [ADDR_W-1:0] paddr;
	logic [DATA_W-1:0] pwdata;
	logic [DATA_W-1:0] prdata;
	logic              pready;
	logic              pslverr;
	int                fail_count;
	int                num_checks;
	int                seed;
	logic [DATA_W-1:0] rd_v;
	logic              rd_err;
	logic [ACC_W-1:0]  m_src;
	logic [ACC_W-1:0]  m_res;

	sru_top u_dut (
		.CLK_SYS (clk_sys),
		.RESET_N (reset_n),
		.PSEL    (psel),
		.PENABLE (penable),
		.PWRITE  (pwrite),
		.PADDR   (paddr),
		.PWDATA  (pwdata),
		.PRDATA  (prdata),
		.PREADY  (pready),
		.PSLVERR (pslverr)
	);

	// Free-running 10 MHz clock
	initial begin
		clk_sys = 1'b0;
		forever #50 clk_sys = ~clk_sys;
	end

	task automatic check(input logic [DATA_W-1:0] got, input logic [DATA_W-1:0] exp);
		num_checks++;
		if (got !== exp) begin
			fail_count++;
			$display("unexpected at %0t: read %h, wanted %h", $time, got, exp);
		end
	endtask : check

	task automatic summarize;
		$display("checks %0d, mismatches %0d", num_checks, fail_count);
		if (fail_count == 0 && num_checks > 0) begin
			$display("TB: PASS");
		end else begin
			$display("TB: FAIL");
		end
		$finish;
	endtask : summarize

	// One APB transfer; request held until pready is seen high at a rising edge
	task automatic apb(input logic wr, input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] wd);
		@(posedge clk_sys);
		psel    <= 1'b1;
		penable <= 1'b0;
		pwrite  <= wr;
		paddr   <= a;
		pwdata  <= wd;
		@(posedge clk_sys);
		penable <= 1'b1;
		// No local limit: a slave that never answers is caught by the watchdog
		do begin
			@(posedge clk_sys);
		end while (pready !== 1'b1);
		rd_v   = prdata;
		rd_err = pslverr;
		psel    <= 1'b0;
		penable <= 1'b0;
	endtask : apb

	task automatic rd_chk(input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] exp);
		apb(1'b0, a, 32'h0000_0000);
		check(rd_v, exp);
	endtask : rd_chk

	// Reference: bit-by-bit walk, so latency-free whole-word hardware is judged against a plain ring
	function automatic void model(input logic [ACC_W-1:0] s, input logic [DATA_W-1:0] d,
		input sru_flags_t fi, input sru_ctrl_t c, output logic [ACC_W-1:0] r,
		output sru_flags_t fo, output logic ill);
		int         w;
		int         n;
		logic       left;
		logic       cnd;
		logic       nb;
		logic [5:0] f6;
		w = (c.dst == SRU_DST_ACC0 || c.dst == SRU_DST_ACC1) ? 40 : 32;
		ill = c.op > 3'h3 || (c.enc16 && c.paired) || (c.op == 3'h3 && c.enc16) || (c.enc16 && w == 40)
			|| (c.dst == SRU_DST_PTR && (c.op > 3'h1 || c.enc16 || (d != 32'h0000_0001 && d != 32'h0000_0002)));
		r = (w == 40) ? s : {8'h00, s[31:0]};
		fo = fi;
		cnd = fi.condition_bit;
		f6 = d[5:0];
		left = (c.op == 3'h1) || (c.op > 3'h1 && !f6[5]);
		n = (c.op < 3'h2) ? ((d >= 32'(w)) ? w : int'(d)) : (f6[5] ? 64 - int'(f6) : int'(f6));
		for (int i = 0; i < n; i++) begin
			nb = left ? r[w-1] : r[0];
			r = left ? (r << 1) : (r >> 1);
			if (c.op == 3'h3) begin
				r = r | (left ? 40'(cnd) : (40'(cnd) << (w - 1)));
				cnd = nb;
			end
		end
		if (w == 32) begin
			r[39:32] = 8'h00;
		end
		if (c.op == 3'h3) begin
			fo.condition_bit = cnd;
		end else if (c.dst != SRU_DST_PTR) begin
			fo.zero_flag = (r == 40'h00_0000_0000);
			fo.negative_flag = r[w-1];
			fo.data_overflow_flag = (c.dst == SRU_DST_DREG) ? 1'b0 : fi.data_overflow_flag;
			fo.acc0_overflow_flag = (c.dst == SRU_DST_ACC0) ? 1'b0 : fi.acc0_overflow_flag;
			fo.acc1_overflow_flag = (c.dst == SRU_DST_ACC1) ? 1'b0 : fi.acc1_overflow_flag;
		end
		if (ill) begin
			fo = fi;
		end
	endfunction : model

	// Load random operand and flags, issue one control word, then read back every register but the distance
	task automatic run_op(input logic [DATA_W-1:0] cw, input logic [DATA_W-1:0] d);
		logic [ACC_W-1:0] r;
		sru_flags_t       fi;
		sru_flags_t       fo;
		logic             ill;
		sru_ctrl_t        c;
		c = sru_ctrl_t'(cw[CTRL_W-1:0]);
		m_src = {8'($random(seed)), 32'($random(seed))};
		fi = 6'($random(seed));
		apb(1'b1, OFF_SRC_LO, m_src[31:0]);
		apb(1'b1, OFF_SRC_HI, {24'h00_0000, m_src[39:32]});
		apb(1'b1, OFF_DIST, d);
		apb(1'b1, OFF_FLAGS, {26'h000_0000, fi});
		apb(1'b1, OFF_CTRL, cw);
		model(m_src, d, fi, c, r, fo, ill);
		if (!ill) begin
			m_res = r;
			if (c.wb) begin
				m_src = (c.dst == SRU_DST_ACC0 || c.dst == SRU_DST_ACC1) ? r : {m_src[39:32], r[31:0]};
			end
		end
		rd_chk(OFF_RES_LO, m_res[31:0]);
		rd_chk(OFF_RES_HI, {24'h00_0000, m_res[39:32]});
		rd_chk(OFF_FLAGS, {26'h000_0000, fo});
		rd_chk(OFF_SRC_LO, m_src[31:0]);
		rd_chk(OFF_SRC_HI, {24'h00_0000, m_src[39:32]});
		rd_chk(OFF_STATUS, {30'h0000_0000, ill, 1'b0});
		rd_chk(OFF_CTRL, cw & 32'(CTRL_MASK));
		if (ill) begin
			apb(1'b1, OFF_STATUS, 32'h0000_0002);
		end
	endtask : run_op

	// Control word from fields; dest codes 0 pointer, 1 data, 2 acc0, 3 acc1
	task automatic cs(input logic [2:0] op, input logic [1:0] dst, input logic e, input logic p,
		input logic wb, input logic [DATA_W-1:0] d);
		run_op({19'h0_0000, wb, 2'h0, p, e, 2'h0, dst, 1'b0, op}, d);
	endtask : cs

	// Watchdog sized well beyond the expected run of a few thousand cycles
	initial begin
		repeat (40000) @(posedge clk_sys);
		fail_count++;
		summarize();
	end

	initial begin
		seed = 32'h0000_3d99;
		fail_count = 0;
		num_checks = 0;
		m_res = ACC_RST;
		reset_n = 1'b0;
		psel = 1'b0;
		penable = 1'b0;
		pwrite = 1'b0;
		paddr = 8'h00;
		pwdata = 32'h0000_0000;
		repeat (12) @(posedge clk_sys);
		reset_n <= 1'b1;
		// Every register clears on reset
		for (int i = 0; i < 8; i++) begin
			rd_chk(8'(4 * i), 32'h0000_0000);
			check(32'(rd_err), 32'h0000_0000);
		end
		// Unmapped places answer with an error and no data
		apb(1'b0, 8'h20, 32'h0000_0000);
		check(rd_v, 32'h0000_0000);
		check(32'(rd_err), 32'h0000_0001);
		apb(1'b1, 8'h24, 32'h1234_5678);
		check(32'(rd_err), 32'h0000_0001);
		// Rotates: zero, range ends, masked upper bits, accumulators, 2 right against 30 left
		cs(3'h3, 2'h1, 1'b0, 1'b0, 1'b0, 32'h0000_0000);
		cs(3'h3, 2'h1, 1'b0, 1'b0, 1'b1, 32'h0000_001F);
		cs(3'h3, 2'h1, 1'b0, 1'b1, 1'b0, 32'hFFFF_FFE0);
		cs(3'h3, 2'h1, 1'b0, 1'b0, 1'b0, 32'h0000_FFC2);
		cs(3'h3, 2'h2, 1'b0, 1'b0, 1'b1, 32'h0000_0016);
		cs(3'h3, 2'h3, 1'b0, 1'b0, 1'b0, 32'hFFFF_FFE1);
		cs(3'h3, 2'h1, 1'b0, 1'b0, 1'b0, 32'hFFFF_FFFE);
		cs(3'h3, 2'h1, 1'b0, 1'b0, 1'b0, 32'h0000_001E);
		cs(3'h3, 2'h1, 1'b0, 1'b0, 1'b0, 32'h0000_0001);
		cs(3'h3, 2'h2, 1'b0, 1'b0, 1'b0, 32'h0000_003F);
		cs(3'h3, 2'h3, 1'b0, 1'b0, 1'b0, 32'h0000_0040);
		// Shifts at the width boundaries and on pointers
		cs(3'h2, 2'h1, 1'b0, 1'b0, 1'b0, 32'h0000_0020);
		cs(3'h2, 2'h2, 1'b0, 1'b0, 1'b1, 32'hFFFF_FFE0);
		cs(3'h2, 2'h3, 1'b0, 1'b0, 1'b0, 32'h0000_001F);
		cs(3'h2, 2'h1, 1'b0, 1'b0, 1'b0, 32'h0000_0000);
		cs(3'h2, 2'h1, 1'b0, 1'b0, 1'b0, 32'hFFFF_FFFF);
		cs(3'h1, 2'h1, 1'b0, 1'b0, 1'b0, 32'h0000_0001);
		cs(3'h1, 2'h1, 1'b0, 1'b0, 1'b0, 32'h0000_0100);
		cs(3'h0, 2'h1, 1'b1, 1'b0, 1'b1, 32'h0000_0020);
		cs(3'h1, 2'h1, 1'b1, 1'b0, 1'b0, 32'h0000_001F);
		cs(3'h0, 2'h2, 1'b0, 1'b0, 1'b0, 32'h0000_0027);
		cs(3'h1, 2'h3, 1'b0, 1'b0, 1'b0, 32'h0000_0028);
		cs(3'h0, 2'h0, 1'b0, 1'b0, 1'b1, 32'h0000_0001);
		cs(3'h1, 2'h0, 1'b0, 1'b1, 1'b0, 32'h0000_0002);
		// Refused forms set the illegal bit and leave result, flags and source alone
		cs(3'h0, 2'h0, 1'b0, 1'b0, 1'b0, 32'h0000_0003);
		cs(3'h2, 2'h0, 1'b0, 1'b0, 1'b0, 32'h0000_0001);
		cs(3'h1, 2'h1, 1'b1, 1'b1, 1'b1, 32'h0000_0001);
		cs(3'h3, 2'h1, 1'b1, 1'b0, 1'b0, 32'h0000_0001);
		cs(3'h0, 2'h2, 1'b1, 1'b0, 1'b0, 32'h0000_0001);
		run_op(32'hFFFF_FFFF, 32'h0000_0001);
		// Result registers ignore software writes
		apb(1'b1, OFF_RES_LO, 32'($random(seed)));
		rd_chk(OFF_RES_LO, m_res[31:0]);
		// Random mix of all ops, dests and forms
		for (int i = 0; i < 120; i++) begin
			cs(3'($random(seed)), 2'($random(seed)), (($random(seed) & 7) == 0), 1'($random(seed)),
				1'($random(seed)), ((i % 2) == 0) ? 32'({$random(seed)} % 48) : 32'($random(seed)));
		end
		summarize();
	end

endmodule : shift_rotate_unit_test
